//--- logic/pwt_top.v
// Eight-channel PWM timer: register port, clock sources, counters, outputs.
// Assumes all inputs are synchronous to SYS_CLK and the register port
// strobes are one cycle long and never both high at once.
//
// Contract
// - Eight channels, 8-bit resolution, each with its own dedicated counter.
// - Each channel repeats its waveform continuously without software help.
// - Pairs 7:6, 5:4, 3:2, 1:0 can join into one 16-bit channel.
// - Any mix of joined and single pairs: 8/0 through 0/4.
// - Programmable period and duty; duty spans zero to full hundred percent except at maximum period in centre mode.
// - Polarity selectable per channel.
// - Left or centre alignment selectable per channel.
// - Enable per channel; disabled channel stops its waveform.
// - Period and duty buffered; applied at counter zero or while disabled.
// - Four clock sources: A, B and scaled versions of each.
`timescale 1ns/1ps
`include "pwt_regs.vh"

module pwt_top (
  input  wire       SYS_CLK,
  input  wire       RST_N,
  input  wire [5:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  input  wire       SHUTDOWN_IN,
  output reg  [7:0] RDATA,
  output reg  [7:0] PWM_OUT
);

  reg  [7:0]  enable;
  reg  [7:0]  polarity;
  reg  [7:0]  align;
  reg  [7:0]  clksel_lo;
  reg  [7:0]  clksel_hi;
  reg  [3:0]  concat;
  reg  [7:0]  prescale;
  reg  [7:0]  scale_a;
  reg  [7:0]  scale_b;
  reg         sd_flag;
  reg         sd_level;
  reg         sd_inen;
  reg  [63:0] per_buf;
  reg  [63:0] duty_buf;
  reg  [63:0] per_act;
  reg  [63:0] duty_act;
  reg  [7:0]  pre_cnt;
  reg  [7:0]  sa_cnt;
  reg  [7:0]  sb_cnt;
  reg  [7:0]  next_rdata;
  wire [15:0] clksel;
  wire [7:0]  mask_a;
  wire [7:0]  mask_b;
  wire        ce_a;
  wire        ce_b;
  wire        ce_sa;
  wire        ce_sb;
  wire [3:0]  ce_src;
  wire [7:0]  tick;
  wire [7:0]  load;
  wire [7:0]  next_out;
  wire [63:0] cnt_rd;
  wire [127:0] cnt_all;
  wire        sd_set;
  wire        sd_clr;
  integer     k;

  assign clksel = {clksel_hi, clksel_lo};

  // Primary sources divide SYS_CLK by a power of two from a free prescaler
  assign mask_a = ~(`PWT_ONES << prescale[`PWT_PRE_A_F]);
  assign mask_b = ~(`PWT_ONES << prescale[`PWT_PRE_B_F]);
  assign ce_a   = (pre_cnt & mask_a) == mask_a;
  assign ce_b   = (pre_cnt & mask_b) == mask_b;
  // Scaled sources pulse once every scale count of their primary; zero means 256
  assign ce_sa  = ce_a && (sa_cnt == `PWT_RST_BYTE);
  assign ce_sb  = ce_b && (sb_cnt == `PWT_RST_BYTE);
  assign ce_src = {ce_sb, ce_sa, ce_b, ce_a};

  // Prescaler and scalers run free so channels sharing a source stay in step
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_cnt <= `PWT_RST_BYTE;
      sa_cnt  <= `PWT_RST_BYTE;
      sb_cnt  <= `PWT_RST_BYTE;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
      if (ce_a) begin
        sa_cnt <= (sa_cnt == `PWT_RST_BYTE) ? scale_a - 8'h01 : sa_cnt - 8'h01;
      end
      if (ce_b) begin
        sb_cnt <= (sb_cnt == `PWT_RST_BYTE) ? scale_b - 8'h01 : sb_cnt - 8'h01;
      end
    end
  end

  // Shutdown flag: a new trip in the clearing cycle wins over the clear
  assign sd_set = (sd_inen && SHUTDOWN_IN) ||
                  (WR && ADDR == `PWT_A_SHUTDOWN && WDATA[`PWT_SD_FORCE]);
  assign sd_clr = WR && ADDR == `PWT_A_SHUTDOWN && WDATA[`PWT_SD_FLAG];

  // Register writes; period and duty land in the buffers only
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable    <= `PWT_RST_BYTE;
      polarity  <= `PWT_RST_BYTE;
      align     <= `PWT_RST_BYTE;
      clksel_lo <= `PWT_RST_BYTE;
      clksel_hi <= `PWT_RST_BYTE;
      concat    <= 4'h0;
      prescale  <= `PWT_RST_BYTE;
      scale_a   <= `PWT_RST_BYTE;
      scale_b   <= `PWT_RST_BYTE;
      sd_flag   <= 1'b0;
      sd_level  <= 1'b0;
      sd_inen   <= 1'b0;
      per_buf   <= {8{`PWT_RST_PERIOD}};
      duty_buf  <= {8{`PWT_RST_DUTY}};
    end else begin
      sd_flag <= sd_set || (sd_flag && !sd_clr);
      if (WR) begin
        case (ADDR)
          `PWT_A_ENABLE:    enable    <= WDATA;
          `PWT_A_POLARITY:  polarity  <= WDATA;
          `PWT_A_ALIGN:     align     <= WDATA;
          `PWT_A_CLKSEL_LO: clksel_lo <= WDATA;
          `PWT_A_CLKSEL_HI: clksel_hi <= WDATA;
          `PWT_A_CONCAT:    concat    <= WDATA[3:0];
          `PWT_A_PRESCALE:  prescale  <= WDATA;
          `PWT_A_SCALE_A:   scale_a   <= WDATA;
          `PWT_A_SCALE_B:   scale_b   <= WDATA;
          `PWT_A_SHUTDOWN: begin
            sd_level <= WDATA[`PWT_SD_LEVEL];
            sd_inen  <= WDATA[`PWT_SD_INEN];
          end
          default: begin
            if (ADDR[`PWT_GRP_F] == `PWT_GRP_PERIOD) begin
              per_buf[8*ADDR[`PWT_IDX_F] +: 8] <= WDATA;
            end
            if (ADDR[`PWT_GRP_F] == `PWT_GRP_DUTY) begin
              duty_buf[8*ADDR[`PWT_IDX_F] +: 8] <= WDATA;
            end
          end
        endcase
      end
    end
  end

  // Buffered values go live at end of period or while the channel is idle
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      per_act  <= {8{`PWT_RST_PERIOD}};
      duty_act <= {8{`PWT_RST_DUTY}};
    end else begin
      for (k = 0; k < 8; k = k + 1) begin
        if (load[k]) begin
          per_act[8*k +: 8]  <= per_buf[8*k +: 8];
          duty_act[8*k +: 8] <= duty_buf[8*k +: 8];
        end
      end
    end
  end

  // One counter per channel; a joined pair runs on the odd channel's counter
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_chan
      localparam integer LO = (i / 2) * 2;
      localparam integer HI = LO + 1;
      localparam integer ODD = i % 2;
      wire        wide = concat[i/2];
      // The even half of a joined pair idles; the odd half owns the pin
      wire        run  = enable[i] && !(wide && ODD == 0);
      wire [15:0] per  = wide ? {per_act[8*HI +: 8], per_act[8*LO +: 8]}
                              : {8'h00, per_act[8*i +: 8]};
      wire [15:0] duty = wide ? {duty_act[8*HI +: 8], duty_act[8*LO +: 8]}
                              : {8'h00, duty_act[8*i +: 8]};
      wire        ce   = ce_src[clksel[2*i +: 2]];
      reg  [15:0] cnt;
      reg         down;
      wire        last_left = ({1'b0, cnt} + `PWT_ONE17) >= {1'b0, per};
      wire        last_ctr  = down && (cnt <= `PWT_ONE16);
      wire        wrap = (per == `PWT_ZERO16) || (align[i] ? last_ctr : last_left);
      // Full duty when duty reaches period in left mode or exceeds it in centre mode, none when duty is zero
      wire        active = cnt < duty;

      assign tick[i] = !run || (ce && wrap);
      assign load[i] = wide ? tick[HI] : tick[i];
      assign next_out[i] = !run ? !polarity[i] :
                           sd_flag ? sd_level :
                           (active ? polarity[i] : !polarity[i]);
      // Counters gathered in one bus so the even half of a pair can read its partner
      assign cnt_all[16*i +: 16] = cnt;
      assign cnt_rd[8*i +: 8] = (wide && ODD == 1) ? cnt[15:8] :
                                (wide ? cnt_all[16*HI +: 8] : cnt[7:0]);

      // Left mode counts 0..period-1; centre mode counts up to period and back
      always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          cnt  <= `PWT_ZERO16;
          down <= 1'b0;
        end else if (!run) begin
          cnt  <= `PWT_ZERO16;
          down <= 1'b0;
        end else if (ce) begin
          if (wrap) begin
            cnt  <= `PWT_ZERO16;
            down <= 1'b0;
          end else if (!align[i]) begin
            cnt <= cnt + `PWT_ONE16;
          end else if (down) begin
            cnt <= cnt - `PWT_ONE16;
          end else begin
            cnt <= cnt + `PWT_ONE16;
            if (last_left) begin
              down <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // Pins come straight from flops; wide pairs drive the odd pin only
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PWM_OUT <= `PWT_RST_BYTE;
    end else begin
      PWM_OUT <= next_out;
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    next_rdata = `PWT_RST_BYTE;
    case (ADDR)
      `PWT_A_ENABLE:    next_rdata = enable;
      `PWT_A_POLARITY:  next_rdata = polarity;
      `PWT_A_ALIGN:     next_rdata = align;
      `PWT_A_CLKSEL_LO: next_rdata = clksel_lo;
      `PWT_A_CLKSEL_HI: next_rdata = clksel_hi;
      `PWT_A_CONCAT:    next_rdata = {4'h0, concat};
      `PWT_A_PRESCALE:  next_rdata = prescale;
      `PWT_A_SCALE_A:   next_rdata = scale_a;
      `PWT_A_SCALE_B:   next_rdata = scale_b;
      `PWT_A_SHUTDOWN:  next_rdata = {5'h00, sd_inen, sd_level, sd_flag};
      `PWT_A_OUTPUT:    next_rdata = PWM_OUT;
      default: begin
        if (ADDR[`PWT_GRP_F] == `PWT_GRP_PERIOD) begin
          next_rdata = per_buf[8*ADDR[`PWT_IDX_F] +: 8];
        end else if (ADDR[`PWT_GRP_F] == `PWT_GRP_DUTY) begin
          next_rdata = duty_buf[8*ADDR[`PWT_IDX_F] +: 8];
        end else if (ADDR[`PWT_GRP_F] == `PWT_GRP_COUNT) begin
          next_rdata = cnt_rd[8*ADDR[`PWT_IDX_F] +: 8];
        end
      end
    endcase
  end

  // Read data stands for one cycle after the strobe, zero otherwise
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= `PWT_RST_BYTE;
    end else begin
      RDATA <= RD ? next_rdata : `PWT_RST_BYTE;
    end
  end

endmodule

//--- common/pwt_regs.vh
// Register map, field positions and reset values of the eight-channel PWM timer.
// Assumes the includer uses an 8-bit data port and a 6-bit register address.
`ifndef PWT_REGS_VH
`define PWT_REGS_VH

// Control registers
`define PWT_A_ENABLE     6'h00
`define PWT_A_POLARITY   6'h01
`define PWT_A_ALIGN      6'h02
`define PWT_A_CLKSEL_LO  6'h03
`define PWT_A_CLKSEL_HI  6'h04
`define PWT_A_CONCAT     6'h05
`define PWT_A_PRESCALE   6'h06
`define PWT_A_SCALE_A    6'h07
`define PWT_A_SCALE_B    6'h08
`define PWT_A_SHUTDOWN   6'h09
`define PWT_A_OUTPUT     6'h0A

// Per-channel groups: ADDR[5:3] picks the group, ADDR[2:0] the channel
`define PWT_GRP_F        5:3
`define PWT_IDX_F        2:0
`define PWT_GRP_PERIOD   3'h2
`define PWT_GRP_DUTY     3'h3
`define PWT_GRP_COUNT    3'h4

// Fields
`define PWT_PRE_A_F      2:0
`define PWT_PRE_B_F      6:4
`define PWT_SD_FLAG      0
`define PWT_SD_LEVEL     1
`define PWT_SD_INEN      2
`define PWT_SD_FORCE     3

// Clock source codes
`define PWT_SRC_A        2'h0
`define PWT_SRC_B        2'h1
`define PWT_SRC_SA       2'h2
`define PWT_SRC_SB       2'h3

// Reset values and constants
`define PWT_RST_BYTE     8'h00
`define PWT_RST_PERIOD   8'hFF
`define PWT_RST_DUTY     8'h00
`define PWT_ONES         8'hFF
`define PWT_ONE16        16'h0001
`define PWT_ZERO16       16'h0000
`define PWT_ONE17        17'h00001

`endif

//--- sim/pwt_top_sva.sv
// Checker for the PWM timer top: relations between its ports only.
// Assumes SYS_CLK rising edge and RST_N asynchronous, active low.
`timescale 1ns/1ps
module pwt_chk (
  input wire       SYS_CLK,
  input wire       RST_N,
  input wire [5:0] ADDR,
  input wire [7:0] WDATA,
  input wire       WR,
  input wire       RD,
  input wire       SHUTDOWN_IN,
  input wire [7:0] RDATA,
  input wire [7:0] PWM_OUT
);
  reg     [7:0] sh [0:63];
  reg     [7:0] exp_rd;
  integer       i;
  wire    [7:0] en  = sh[0];
  wire    [7:0] pol = sh[1];
  wire          lvl = sh[9][1];
  // Even pins of joined pairs never run, so shutdown leaves them alone
  wire    [7:0] run = {1'b1, ~sh[5][3], 1'b1, ~sh[5][2], 1'b1, ~sh[5][1], 1'b1, ~sh[5][0]};

  // Shadow of written values; read data predicted one cycle ahead
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (i = 0; i < 64; i = i + 1)
        sh[i] <= (i >= 16 && i < 24) ? 8'hFF : 8'h00;
      exp_rd <= 8'h00;
    end else begin
      if (WR)
        sh[ADDR] <= (ADDR == 6'h05) ? {4'h0, WDATA[3:0]} : WDATA;
      exp_rd <= sh[ADDR];
    end
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not idle");
  enable_readback_a: assert property (RD && ADDR == 6'h00 |=> RDATA == exp_rd)
    else $error("enable readback wrong");
  ctrl_readback_a: assert property (RD && ADDR > 6'h00 && ADDR < 6'h09 |=> RDATA == exp_rd)
    else $error("control readback wrong");
  period_readback_a: assert property (RD && ADDR[5:3] == 3'h2 |=> RDATA == exp_rd)
    else $error("period readback wrong");
  duty_readback_a: assert property (RD && ADDR[5:3] == 3'h3 |=> RDATA == exp_rd)
    else $error("duty readback wrong");
  unmapped_zero_a: assert property (RD && ADDR[5:3] > 3'h4 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  output_readback_a: assert property (RD && ADDR == 6'h0A |=> RDATA == $past(PWM_OUT))
    else $error("output readback wrong");
  disabled_level_a: assert property ($past(RST_N) && en == 8'h00 && $past(en) == 8'h00
    && $stable(pol) |-> PWM_OUT == ~pol)
    else $error("disabled output not inactive");
  shutdown_force_a: assert property (SHUTDOWN_IN && sh[9][2] ##1 SHUTDOWN_IN |=> ##1
    (!$stable(lvl) || ((PWM_OUT ^ {8{lvl}}) & $past(en) & run) == 8'h00))
    else $error("shutdown did not force outputs");

  cover property (RD && ADDR == 6'h0A);
  cover property (SHUTDOWN_IN && sh[9][2]);
  cover property ($rose(PWM_OUT[3]));
endmodule

bind pwt_top pwt_chk pwt_chk_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .SHUTDOWN_IN(SHUTDOWN_IN), .RDATA(RDATA),
  .PWM_OUT(PWM_OUT));

//--- sim/pwt_tb.sv
// Self-checking bench for the eight-channel PWM timer.
// Assumes pwt_top and pwt_regs.vh are on the compile and include paths.
`timescale 1ns/1ps
`include "pwt_regs.vh"
module tb;
  logic        SYS_CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [5:0]  ADDR = 6'h00;
  logic [7:0]  WDATA = 8'h00;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        SHUTDOWN_IN = 1'b0;
  wire  [7:0]  RDATA;
  wire  [7:0]  PWM_OUT;
  int          failures = 0;
  int          total_checks = 0;
  int          ones [8];
  int          rises [8];
  logic [7:0]  rd;
  // Channel 7 down to 0: periods, duties, expected high and rising counts
  logic [63:0]  per = 64'h04_02_04_04_01_00_04_04;
  logic [63:0]  dut = 64'h01_01_00_FF_00_80_02_01;
  logic [127:0] e_on = 128'h0080_0100_0000_0200_0100_0000_00C0_0080;
  logic [127:0] e_rs = 128'h0040_0040_0000_0000_0002_0000_0040_0080;
  // Rows: address, written value, value read back
  logic [21:0]  rows [10] = '{{`PWT_A_POLARITY, 8'hFF, 8'hFF}, {`PWT_A_ALIGN, 8'h02, 8'h02},
    {`PWT_A_CLKSEL_LO, 8'h00, 8'h00}, {`PWT_A_CLKSEL_HI, 8'h78, 8'h78},
    {`PWT_A_CONCAT, 8'h02, 8'h02}, {`PWT_A_PRESCALE, 8'h10, 8'h10},
    {`PWT_A_SCALE_A, 8'h03, 8'h03}, {`PWT_A_SCALE_B, 8'h02, 8'h02},
    {6'h0B, 8'h5A, 8'h00}, {6'h3F, 8'hA5, 8'h00}};

  pwt_top pwt_top_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .SHUTDOWN_IN(SHUTDOWN_IN), .RDATA(RDATA), .PWM_OUT(PWM_OUT));

  // Free-running system clock, 50 ns period
  always #25 SYS_CLK = ~SYS_CLK;

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Strobe lowered one edge later, so back-to-back calls never clash
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
    @(posedge SYS_CLK);
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rreg(input logic [5:0] a);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 rd = RDATA;
    @(posedge SYS_CLK);
  endtask

  // 512 cycles is a whole number of periods for every channel except channel 5, whose duty is zero
  task automatic measure();
    logic [7:0] prev;
    #1 prev = PWM_OUT;
    ones = '{default: 0};
    rises = '{default: 0};
    repeat (512) begin
      @(posedge SYS_CLK);
      #1;
      for (int b = 0; b < 8; b++) begin
        ones[b] += PWM_OUT[b];
        rises[b] += PWM_OUT[b] & ~prev[b];
      end
      prev = PWM_OUT;
    end
  endtask

  task automatic summarize();
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    #1 chk("out", PWM_OUT, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      rreg(6'h10 + i[5:0]);
      chk("period", rd, 8'hFF);
      wr(6'h10 + i[5:0], per[i*8+:8]);
      wr(6'h18 + i[5:0], dut[i*8+:8]);
      rreg(6'h18 + i[5:0]);
      chk("duty", rd, dut[i*8+:8]);
    end
    foreach (rows[i]) begin
      wr(rows[i][21:16], rows[i][15:8]);
      rreg(rows[i][21:16]);
      chk("reg", rd, rows[i][7:0]);
    end
    wr(`PWT_A_ENABLE, 8'hFB);
    // Scalers may still be running out a 256 count loaded before setup
    repeat (600) @(posedge SYS_CLK);
    measure();
    for (int b = 0; b < 8; b++) begin
      chk("ones", ones[b][15:0], e_on[b*16+:16]);
      chk("rises", rises[b][15:0], e_rs[b*16+:16]);
    end
    rreg(`PWT_A_OUTPUT);
    wr(6'h18, 8'h02);
    repeat (8) @(posedge SYS_CLK);
    measure();
    chk("buffered", ones[0][15:0], 16'h0100);
    wr(`PWT_A_SHUTDOWN, 8'h06);
    SHUTDOWN_IN <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    SHUTDOWN_IN <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    #1 chk("forced", PWM_OUT, 8'hFB);
    rreg(`PWT_A_SHUTDOWN);
    chk("flag", rd, 8'h07);
    wr(`PWT_A_SHUTDOWN, 8'h07);
    rreg(`PWT_A_SHUTDOWN);
    chk("cleared", rd, 8'h06);
    // Software force beside a clear in the same write: the set wins
    wr(`PWT_A_SHUTDOWN, 8'h0B);
    rreg(`PWT_A_SHUTDOWN);
    chk("force", rd, 8'h03);
    wr(`PWT_A_SHUTDOWN, 8'h01);
    rreg(`PWT_A_SHUTDOWN);
    chk("clear2", rd, 8'h00);
    wr(`PWT_A_ENABLE, 8'h00);
    repeat (2) @(posedge SYS_CLK);
    #1 chk("off", PWM_OUT, 8'h00);
    wr(`PWT_A_POLARITY, 8'h00);
    repeat (2) @(posedge SYS_CLK);
    rreg(`PWT_A_OUTPUT);
    chk("outreg", rd, 8'hFF);
    RST_N <= 1'b0;
    #1 chk("rst", PWM_OUT, 8'h00);
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    #1 chk("idle", PWM_OUT, 8'hFF);
    rreg(`PWT_A_ENABLE);
    chk("enable", rd, 8'h00);
    rreg(6'h10);
    chk("perrst", rd, 8'hFF);
    summarize();
  end

  // Watchdog: the sequence needs about 1800 cycles
  initial begin
    #(50 * 10000);
    failures++;
    summarize();
  end
endmodule
